// [sysctl_pkg.sv]
`default_nettype none
package sysctl_pkg;

  // ------------------------------------------------------------------
  // register selectors (primary_register_selector values)
  // ------------------------------------------------------------------
  localparam logic [3:0] SEL_ID    = 4'h0;
  localparam logic [3:0] SEL_CTRL  = 4'h1;
  localparam logic [3:0] SEL_TTB   = 4'h2;
  localparam logic [3:0] SEL_DAC   = 4'h3;
  localparam logic [3:0] SEL_FSR   = 4'h5;
  localparam logic [3:0] SEL_FAR   = 4'h6;
  localparam logic [3:0] SEL_CACHE = 4'h7;
  localparam logic [3:0] SEL_TLB   = 4'h8;

  // ------------------------------------------------------------------
  // field layouts and reset values
  // ------------------------------------------------------------------
  localparam int          CTRL_W        = 13;
  localparam int          ICACHE_EN_BIT = 12;
  localparam logic [12:0] CTRL_RESET    = 13'h0000;
  localparam int          TTB_LSB       = 14;
  localparam int          TTB_W         = 18;
  localparam logic [17:0] TTB_RESET     = 18'h00000;
  localparam logic [31:0] DAC_RESET     = 32'h0000_0000;
  localparam int          FSR_W         = 8;
  localparam logic [7:0]  FSR_RESET     = 8'h00;
  localparam logic [31:0] FAR_RESET     = 32'h0000_0000;

  // ------------------------------------------------------------------
  // secondary_register_selector and function codes
  // ------------------------------------------------------------------
  localparam logic [3:0] SEC_UNIFIED = 4'h7;
  localparam logic [3:0] SEC_INSTR   = 4'h5;
  localparam logic [3:0] SEC_DATA    = 4'h6;
  localparam logic [3:0] SEC_CLEAN_U = 4'hb;
  localparam logic [3:0] SEC_CLEAN_D = 4'ha;
  localparam logic [3:0] SEC_CF_U    = 4'hf;
  localparam logic [3:0] SEC_CF_D    = 4'he;
  localparam logic [2:0] FN_ALL      = 3'h0;
  localparam logic [2:0] FN_ENTRY    = 3'h1;
  localparam logic [2:0] FN_AUX      = 3'h4;
  localparam logic [2:0] FN_BTC_ALL  = 3'h6;
  localparam logic [2:0] FN_BTC_ONE  = 3'h7;

  typedef enum logic [2:0] {
    OP_NONE        = 3'b000,
    OP_FLUSH       = 3'b001,
    OP_CLEAN       = 3'b010,
    OP_CLEAN_FLUSH = 3'b011,
    OP_PFB_FLUSH   = 3'b100,
    OP_WB_DRAIN    = 3'b101,
    OP_BTC_FLUSH   = 3'b110,
    OP_TLB_INVAL   = 3'b111
  } maint_op_t;

  typedef enum logic [1:0] {
    TGT_UNIFIED = 2'b00,
    TGT_INSTR   = 2'b01,
    TGT_DATA    = 2'b10,
    TGT_NONE    = 2'b11
  } maint_tgt_t;

  typedef struct packed {
    logic        write;
    logic [3:0]  primary;
    logic [3:0]  secondary;
    logic [2:0]  func;
    logic [31:0] wdata;
  } cp_req_t;

  typedef struct packed {
    maint_op_t   op;
    maint_tgt_t  target;
    logic        single;
    logic [31:0] addr;
  } maint_cmd_t;

  typedef struct packed {
    logic        data_side;
    logic [3:0]  domain;
    logic [3:0]  fault_type;
    logic [31:0] vaddr;
  } abort_info_t;

endpackage
`default_nettype wire

// [maint_decode.sv]
`timescale 1ns/100ps
`default_nettype none
module maint_decode
  import sysctl_pkg::*;
#(
  parameter bit SPLIT_CACHE = 1'b1,
  parameter bit SPLIT_TLB   = 1'b1
) (
  input  wire logic        is_tlb_i,
  input  wire logic [3:0]  secondary_i,
  input  wire logic [2:0]  func_i,
  input  wire logic [31:0] wdata_i,
  output var  maint_cmd_t  cmd_o,
  output var  logic        legal_o
);

  // ------------------------------------------------------------------
  // field decode
  // ------------------------------------------------------------------
  wire logic fn_all   = (func_i == FN_ALL);
  wire logic fn_entry = (func_i == FN_ENTRY);
  wire logic fn_ae    = fn_all | fn_entry;
  wire logic sec_u    = (secondary_i == SEC_UNIFIED);
  wire logic sec_i    = (secondary_i == SEC_INSTR);
  wire logic sec_d    = (secondary_i == SEC_DATA);
  wire logic sec_uid  = sec_u | sec_i | sec_d;
  wire logic split    = is_tlb_i ? SPLIT_TLB : SPLIT_CACHE;

  // unified structures treat instruction/data forms as unified
  wire maint_tgt_t uid_tgt = (!split || sec_u) ? TGT_UNIFIED :
                             sec_i ? TGT_INSTR : TGT_DATA;
  wire maint_tgt_t ud_tgt  = (secondary_i[0] || !split) ?
                             TGT_UNIFIED : TGT_DATA;

  maint_op_t op;
  maint_tgt_t tgt;
  logic single;

  always_comb begin
    op     = OP_NONE;
    tgt    = TGT_NONE;
    single = fn_entry;
    if (is_tlb_i) begin
      if (sec_uid && fn_ae) begin
        op  = OP_TLB_INVAL;
        tgt = uid_tgt;
      end
    end else begin
      case (secondary_i)
        SEC_UNIFIED, SEC_DATA: begin
          if (fn_ae) begin
            op  = OP_FLUSH;
            tgt = uid_tgt;
          end
        end
        SEC_INSTR: begin
          if (fn_ae) begin
            op  = OP_FLUSH;
            tgt = uid_tgt;
          end else if (func_i == FN_AUX) begin
            op  = OP_PFB_FLUSH;
          end else if (func_i == FN_BTC_ALL) begin
            op  = OP_BTC_FLUSH;
          end else if (func_i == FN_BTC_ONE) begin
            op     = OP_BTC_FLUSH;
            single = 1'b1;
          end
        end
        SEC_CLEAN_U, SEC_CLEAN_D: begin
          if (fn_ae) begin
            op  = OP_CLEAN;
            tgt = ud_tgt;
          end else if (!secondary_i[0] && func_i == FN_AUX) begin
            op  = OP_WB_DRAIN;
          end
        end
        SEC_CF_U, SEC_CF_D: begin
          if (fn_ae) begin
            op  = OP_CLEAN_FLUSH;
            tgt = ud_tgt;
          end
        end
        default: begin
          op = OP_NONE;
        end
      endcase
    end
  end

  // entry ops carry the address; the cache may widen them
  assign cmd_o   = '{op: op, target: tgt, single: single,
                     addr: wdata_i};
  assign legal_o = (op != OP_NONE);

endmodule // maint_decode
`default_nettype wire

// [sysctl_regs.sv]
`timescale 1ns/100ps
`default_nettype none
module sysctl_regs
  import sysctl_pkg::*;
#(
  parameter bit SPLIT_CACHE = 1'b1,
  parameter bit SPLIT_TLB   = 1'b1
) (
  input  wire logic        ref_clk_i,
  input  wire logic        rstn_i,
  input  wire logic        req_valid_i,
  input  wire cp_req_t     req_i,
  input  wire logic        user_mode_i,
  input  wire logic        abort_valid_i,
  input  wire abort_info_t abort_i,
  input  wire logic        maint_ack_i,
  output var  logic        req_ready_o,
  output var  logic        resp_valid_o,
  output var  logic        resp_undef_o,
  output var  logic [31:0] resp_rdata_o,
  output var  logic [31:0] ctrl_bits_o,
  output var  logic [17:0] ttb_o,
  output var  logic [31:0] domain_access_o,
  output var  logic        maint_req_o,
  output var  maint_cmd_t  maint_cmd_o
);

  // ------------------------------------------------------------------
  // state and storage
  // ------------------------------------------------------------------
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_WAIT = 1'b1
  } seq_state_t;

  seq_state_t  state_ff;
  seq_state_t  nxt_state;
  logic        ready_ff;
  logic        resp_valid_ff;
  logic        resp_undef_ff;
  logic [31:0] rdata_ff;
  logic [12:0] ctrl_ff;
  logic [17:0] ttb_ff;
  logic [31:0] dac_ff;
  logic [7:0]  fsr_ff;
  logic [31:0] far_ff;
  logic        maint_req_ff;
  maint_cmd_t  maint_cmd_ff;
  maint_cmd_t  dec_cmd;
  logic        dec_legal;

  // ------------------------------------------------------------------
  // request decode
  // ------------------------------------------------------------------
  wire logic take     = req_valid_i & ready_ff;
  wire logic priv_ok  = take & ~user_mode_i;
  wire logic user_hit = take & user_mode_i;
  wire logic wr_ok    = priv_ok & req_i.write;
  wire logic rd_ok    = priv_ok & ~req_i.write;
  wire logic [3:0] sel = req_i.primary;

  wire logic wr_ctrl  = wr_ok & (sel == SEL_CTRL);
  wire logic wr_ttb   = wr_ok & (sel == SEL_TTB);
  wire logic wr_dac   = wr_ok & (sel == SEL_DAC);
  wire logic wr_fsr   = wr_ok & (sel == SEL_FSR);
  wire logic wr_far   = wr_ok & (sel == SEL_FAR);
  wire logic wr_maint = wr_ok & ((sel == SEL_CACHE) | (sel == SEL_TLB));
  wire logic start_mt = wr_maint & dec_legal;
  wire logic data_abt = abort_valid_i & abort_i.data_side;
  wire logic mt_done  = (state_ff == ST_WAIT) & maint_ack_i;

  // unknown codes finish at once without an operation
  maint_decode #(
    .SPLIT_CACHE (SPLIT_CACHE),
    .SPLIT_TLB   (SPLIT_TLB)
  ) u_decode (
    .is_tlb_i    (sel == SEL_TLB),
    .secondary_i (req_i.secondary),
    .func_i      (req_i.func),
    .wdata_i     (req_i.wdata),
    .cmd_o       (dec_cmd),
    .legal_o     (dec_legal)
  );

  // ------------------------------------------------------------------
  // next values
  // ------------------------------------------------------------------
  // unified cache keeps bit 12 at its reset value
  wire logic icache_nxt = SPLIT_CACHE ? req_i.wdata[ICACHE_EN_BIT] :
                          ctrl_ff[ICACHE_EN_BIT];
  wire logic [12:0] nxt_ctrl = {icache_nxt, req_i.wdata[11:0]};
  wire logic [17:0] nxt_ttb  = req_i.wdata[31:TTB_LSB];
  // a data abort in the same cycle as a restore wins: fresh state is kept
  wire logic [7:0] nxt_fsr = data_abt ?
                             {abort_i.domain, abort_i.fault_type} :
                             req_i.wdata[FSR_W-1:0];
  wire logic [31:0] nxt_far = data_abt ? abort_i.vaddr :
                              req_i.wdata;

  // undefined bits read zero; function and reserved registers read zero
  wire logic [31:0] rd_mux =
    (sel == SEL_CTRL) ? {19'h00000, ctrl_ff} :
    (sel == SEL_TTB)  ? {ttb_ff, 14'h0000} :
    (sel == SEL_DAC)  ? dac_ff :
    (sel == SEL_FSR)  ? {24'h000000, fsr_ff} :
    (sel == SEL_FAR)  ? far_ff :
                        32'h0000_0000;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (start_mt) begin
          nxt_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (maint_ack_i) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // ------------------------------------------------------------------
  // sequencing and answer
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_ff      <= ST_IDLE;
      ready_ff      <= 1'b0;
      resp_valid_ff <= 1'b0;
      resp_undef_ff <= 1'b0;
      rdata_ff      <= 32'h0000_0000;
    end else begin
      state_ff      <= nxt_state;
      ready_ff      <= (nxt_state == ST_IDLE);
      resp_valid_ff <= (take & ~start_mt) | mt_done;
      resp_undef_ff <= user_hit;
      rdata_ff      <= rd_ok ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      maint_req_ff <= 1'b0;
      maint_cmd_ff <= '{op: OP_NONE, target: TGT_NONE, single: 1'b0,
                        addr: 32'h0000_0000};
    end else if (start_mt) begin
      maint_req_ff <= 1'b1;
      maint_cmd_ff <= dec_cmd;
    end else if (mt_done) begin
      maint_req_ff <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_ff <= CTRL_RESET;
      ttb_ff  <= TTB_RESET;
      dac_ff  <= DAC_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_ff <= nxt_ctrl;
      end
      if (wr_ttb) begin
        ttb_ff <= nxt_ttb;
      end
      if (wr_dac) begin
        dac_ff <= req_i.wdata;
      end
    end
  end

  // prefetch aborts never reach these two registers
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fsr_ff <= FSR_RESET;
      far_ff <= FAR_RESET;
    end else begin
      if (data_abt || wr_fsr) begin
        fsr_ff <= nxt_fsr;
      end
      if (data_abt || wr_far) begin
        far_ff <= nxt_far;
      end
    end
  end

  assign req_ready_o     = ready_ff;
  assign resp_valid_o    = resp_valid_ff;
  assign resp_undef_o    = resp_undef_ff;
  assign resp_rdata_o    = rdata_ff;
  assign ctrl_bits_o     = {19'h00000, ctrl_ff};
  assign ttb_o           = ttb_ff;
  assign domain_access_o = dac_ff;
  assign maint_req_o     = maint_req_ff;
  assign maint_cmd_o     = maint_cmd_ff;

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rstn_i);

  sequence s_mt_ack;
    maint_req_o && maint_ack_i;
  endsequence

  sequence s_mt_reply;
    resp_valid_o && !resp_undef_o && !maint_req_o && req_ready_o;
  endsequence

  sequence s_mt_hold;
    maint_req_o && !req_ready_o && !resp_valid_o;
  endsequence

  user_undef_a: assert property (
    user_hit |=> resp_valid_o && resp_undef_o && resp_rdata_o == 32'h0
  ) else $error("user mode access not refused");

  user_nowrite_a: assert property (
    user_hit |=> $stable(ctrl_bits_o) && $stable(domain_access_o)
                 && !maint_req_o
  ) else $error("user mode access changed state");

  icache_bit_a: assert property (
    wr_ctrl && SPLIT_CACHE |=>
      ctrl_bits_o[ICACHE_EN_BIT] == $past(req_i.wdata[ICACHE_EN_BIT])
  ) else $error("instruction cache enable not written");

  unified_ign_a: assert property (
    !SPLIT_CACHE |-> ctrl_bits_o[ICACHE_EN_BIT] == 1'b0
  ) else $error("unified cache enable bit moved");

  ctrl_upper_a: assert property (
    ctrl_bits_o[31:13] == 19'h0
  ) else $error("control upper bits nonzero");

  ttb_write_a: assert property (
    wr_ttb |=> ttb_o == $past(req_i.wdata[31:14])
  ) else $error("table base not loaded");

  ttb_read_a: assert property (
    rd_ok && sel == SEL_TTB |=> resp_valid_o && resp_rdata_o[31:14] == ttb_o
  ) else $error("table base read mismatch");

  dac_rw_a: assert property (
    wr_dac |=> domain_access_o == $past(req_i.wdata)
  ) else $error("domain access write lost");

  dac_read_a: assert property (
    rd_ok && sel == SEL_DAC |=> resp_rdata_o == domain_access_o
  ) else $error("domain access read back wrong");

  fsr_read_a: assert property (
    rd_ok && sel == SEL_FSR |=>
      resp_rdata_o[31:8] == 24'h0 && resp_rdata_o[7:0] == $past(fsr_ff)
  ) else $error("fault status read layout wrong");

  fsr_pref_a: assert property (
    abort_valid_i && !abort_i.data_side && !wr_fsr && !wr_far |=>
      $stable(fsr_ff) && $stable(far_ff)
  ) else $error("prefetch abort updated fault state");

  fsr_data_a: assert property (
    data_abt |=> fsr_ff == {$past(abort_i.domain), $past(abort_i.fault_type)}
  ) else $error("data abort not captured in status");

  fsr_write_a: assert property (
    wr_fsr && !data_abt |=> fsr_ff == $past(req_i.wdata[7:0])
  ) else $error("fault status restore failed");

  far_data_a: assert property (
    data_abt |=> far_ff == $past(abort_i.vaddr)
  ) else $error("data abort address not captured");

  far_write_a: assert property (
    wr_far && !data_abt |=> far_ff == $past(req_i.wdata)
  ) else $error("fault address restore failed");

  flush_all_a: assert property (
    start_mt && sel == SEL_CACHE && req_i.secondary == SEC_UNIFIED
      && req_i.func == FN_ALL |=>
      maint_cmd_o.op == OP_FLUSH && maint_cmd_o.target == TGT_UNIFIED
      && !maint_cmd_o.single
  ) else $error("whole cache flush decoded wrong");

  clean_a: assert property (
    start_mt && sel == SEL_CACHE && req_i.secondary == SEC_CLEAN_D
      && req_i.func == FN_ENTRY |=>
      maint_cmd_o.op == OP_CLEAN && maint_cmd_o.single
      && maint_cmd_o.addr == $past(req_i.wdata)
  ) else $error("clean entry decoded wrong");

  drain_a: assert property (
    start_mt && sel == SEL_CACHE && req_i.secondary == SEC_CLEAN_D
      && req_i.func == FN_AUX |=> maint_cmd_o.op == OP_WB_DRAIN
  ) else $error("write buffer drain decoded wrong");

  tlb_unif_a: assert property (
    maint_req_o && maint_cmd_o.op == OP_TLB_INVAL && !SPLIT_TLB |->
      maint_cmd_o.target == TGT_UNIFIED
  ) else $error("unified TLB got split target");

  mt_block_a: assert property (
    start_mt |=> s_mt_hold
  ) else $error("maintenance did not block requests");

  mt_wait_a: assert property (
    maint_req_o && !maint_ack_i |=> s_mt_hold
  ) else $error("maintenance dropped before ack");

  mt_end_a: assert property (
    s_mt_ack |=> s_mt_reply
  ) else $error("maintenance completion not answered");

  reg_resp_a: assert property (
    take && !start_mt |=> resp_valid_o ##1 !resp_valid_o || $past(take)
  ) else $error("register access answer missing");

endmodule // sysctl_regs
`default_nettype wire

// [maint_responder.sv]
`timescale 1ns/100ps
`default_nettype none
module maint_responder (
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  input  wire logic       req_i,
  input  wire logic [3:0] wait_i,
  output var  logic       ack_o
);
  // ------------------------------------------------------------------
  // cache/tlb side: finishes an op after wait_i idle cycles
  // ------------------------------------------------------------------
  // a variable stall exercises both prompt and slow completion
  logic [3:0] cnt_ff;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_ff <= 4'h0;
      ack_o  <= 1'b0;
    end else if (!req_i || ack_o) begin
      // one ack per op, never while idle
      cnt_ff <= 4'h0;
      ack_o  <= 1'b0;
    end else begin
      cnt_ff <= cnt_ff + 4'h1;
      ack_o  <= (cnt_ff == wait_i);
    end
  end
endmodule // maint_responder
`default_nettype wire

// [system_control_coprocessor_regs_bench.sv]
`timescale 1ns/100ps
`default_nettype none
module system_control_coprocessor_regs_bench import sysctl_pkg::*;;
  // ------------------------------------------------------------------
  // stimulus and observation
  // ------------------------------------------------------------------
  logic        ref_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        req_valid = 1'b0;
  cp_req_t     req = '0;
  logic        user_mode = 1'b0;
  logic        abort_valid = 1'b0;
  abort_info_t abort = '0;
  logic [3:0]  ack_wait = 4'h0;
  logic        maint_ack, req_ready, resp_valid, resp_undef, maint_req;
  logic [31:0] rdata, ctrl_bits, dac, got;
  logic [17:0] ttb;
  maint_cmd_t  mcmd, seen_cmd;
  logic        got_undef, seen_req, busy_ready;
  int          num_errors = 0;
  int          compares = 0;
  int          cycles = 0;
  logic [3:0]  secs [7] = '{4'h7, 4'h5, 4'h6, 4'hb, 4'ha, 4'hf, 4'he};
  maint_op_t   ops [7] = '{OP_FLUSH, OP_FLUSH, OP_FLUSH, OP_CLEAN,
                           OP_CLEAN, OP_CLEAN_FLUSH, OP_CLEAN_FLUSH};
  maint_tgt_t  tgts [7] = '{TGT_UNIFIED, TGT_INSTR, TGT_DATA, TGT_UNIFIED,
                            TGT_DATA, TGT_UNIFIED, TGT_DATA};

  always #20 ref_clk = ~ref_clk;

  sysctl_regs uut (.ref_clk_i(ref_clk), .rstn_i(rstn),
    .req_valid_i(req_valid), .req_i(req), .user_mode_i(user_mode),
    .abort_valid_i(abort_valid), .abort_i(abort), .maint_ack_i(maint_ack),
    .req_ready_o(req_ready), .resp_valid_o(resp_valid),
    .resp_undef_o(resp_undef), .resp_rdata_o(rdata),
    .ctrl_bits_o(ctrl_bits), .ttb_o(ttb), .domain_access_o(dac),
    .maint_req_o(maint_req), .maint_cmd_o(mcmd));

  maint_responder far_side (.clk_i(ref_clk), .rstn_i(rstn),
    .req_i(maint_req), .wait_i(ack_wait), .ack_o(maint_ack));

  // ------------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] act);
    compares++;
    if (act !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, act);
    end
  endtask

  task automatic xfer(input logic wr, input logic [3:0] prim,
                      input logic [3:0] sec, input logic [2:0] fn,
                      input logic [31:0] wd);
    int n;
    // only registers 1-3 and 5-8 are ever addressed
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req <= '{write: wr, primary: prim, secondary: sec, func: fn, wdata: wd};
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (req_ready !== 1'b1 && n < 50);
    req_valid <= 1'b0;
    seen_req = 1'b0;
    busy_ready = 1'b0;
    for (n = 0; n < 40; n++) begin
      @(posedge ref_clk);
      if (maint_req === 1'b1) begin
        seen_req = 1'b1;
        seen_cmd = mcmd;
        // nothing new may be taken while an op is outstanding
        if (req_ready !== 1'b0) busy_ready = 1'b1;
      end
      if (resp_valid === 1'b1) break;
    end
    if (n == 40) chk("response", 32'h1, 32'h0);
    got = rdata;
    got_undef = resp_undef;
  endtask

  task automatic pulse_abort(input logic ds, input logic [31:0] va);
    @(posedge ref_clk);
    abort_valid <= 1'b1;
    abort <= '{data_side: ds, domain: 4'hc, fault_type: 4'h5, vaddr: va};
    @(posedge ref_clk);
    abort_valid <= 1'b0;
  endtask

  task automatic mop(input logic [3:0] prim, input logic [3:0] sec,
                     input logic [2:0] fn, input maint_op_t op,
                     input maint_tgt_t tgt, input logic one, input bit full);
    xfer(1'b1, prim, sec, fn, 32'h4000_0040);
    chk("maint_seen", 32'h1, {31'h0, seen_req});
    chk("ready_busy", 32'h0, {31'h0, busy_ready});
    chk("op", {29'h0, op}, {29'h0, seen_cmd.op});
    if (full) begin
      chk("target", {30'h0, tgt}, {30'h0, seen_cmd.target});
      chk("single", {31'h0, one}, {31'h0, seen_cmd.single});
      if (one) chk("addr", 32'h4000_0040, seen_cmd.addr);
    end
  endtask

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_reset;
    xfer(1'b0, SEL_CTRL, 4'h0, 3'h0, '0);
    chk("ctrl_read", 32'h0, got);
    chk("ctrl_out", 32'h0, ctrl_bits);
  endtask

  task automatic t_ctrl;
    // translation stays on whenever a cache is enabled
    xfer(1'b1, SEL_CTRL, 4'h0, 3'h0, 32'h0000_1005);
    xfer(1'b0, SEL_CTRL, 4'h0, 3'h0, '0);
    chk("ctrl_icache_on", 32'h0000_1005, got);
    xfer(1'b1, SEL_CTRL, 4'h0, 3'h0, 32'h0000_0005);
    chk("ctrl_icache_off", 32'h0000_0005, ctrl_bits);
  endtask

  task automatic t_ttb_dac;
    xfer(1'b1, SEL_TTB, 4'h0, 3'h0, 32'habcd_c000);
    xfer(1'b0, SEL_TTB, 4'h0, 3'h0, '0);
    chk("ttb_read", 32'habcd_c000, got);
    chk("ttb_out", 32'h0002_af37, {14'h0, ttb});
    xfer(1'b1, SEL_DAC, 4'h0, 3'h0, 32'hc63a_5e81);
    xfer(1'b0, SEL_DAC, 4'h0, 3'h0, '0);
    chk("dac_read", 32'hc63a_5e81, got);
    chk("dac_out", 32'hc63a_5e81, dac);
  endtask

  task automatic t_fault;
    xfer(1'b1, SEL_FSR, 4'h0, 3'h0, 32'h0000_005a);
    xfer(1'b1, SEL_FAR, 4'h0, 3'h0, 32'h8765_4320);
    pulse_abort(1'b0, 32'h1234_5678);
    xfer(1'b0, SEL_FSR, 4'h0, 3'h0, '0);
    chk("fsr_restore", 32'h0000_005a, got);
    xfer(1'b0, SEL_FAR, 4'h0, 3'h0, '0);
    chk("far_restore", 32'h8765_4320, got);
    pulse_abort(1'b1, 32'hdead_bee0);
    xfer(1'b0, SEL_FSR, 4'h0, 3'h0, '0);
    chk("fsr_abort", 32'h0000_00c5, got);
    xfer(1'b0, SEL_FAR, 4'h0, 3'h0, '0);
    chk("far_abort", 32'hdead_bee0, got);
  endtask

  task automatic t_user;
    user_mode <= 1'b1;
    xfer(1'b1, SEL_DAC, 4'h0, 3'h0, 32'hffff_ffff);
    chk("user_undef", 32'h1, {31'h0, got_undef});
    user_mode <= 1'b0;
    xfer(1'b0, SEL_DAC, 4'h0, 3'h0, '0);
    chk("priv_undef", 32'h0, {31'h0, got_undef});
    chk("dac_kept", 32'hc63a_5e81, got);
  endtask

  task automatic t_maint;
    for (int i = 0; i < 7; i++) begin
      for (int f = 0; f < 2; f++) begin
        ack_wait <= 4'(i + f);
        mop(SEL_CACHE, secs[i], 3'(f), ops[i], tgts[i], 1'(f), 1'b1);
      end
    end
    ack_wait <= 4'h9;
    for (int i = 0; i < 3; i++) begin
      mop(SEL_TLB, secs[i], FN_ALL, OP_TLB_INVAL, tgts[i], 1'b0, 1'b1);
      mop(SEL_TLB, secs[i], FN_ENTRY, OP_TLB_INVAL, tgts[i], 1'b1, 1'b1);
    end
    ack_wait <= 4'h0;
    mop(SEL_CACHE, SEC_INSTR, FN_AUX, OP_PFB_FLUSH, TGT_NONE, 1'b0, 1'b0);
    mop(SEL_CACHE, SEC_CLEAN_D, FN_AUX, OP_WB_DRAIN, TGT_NONE, 1'b0, 1'b0);
    mop(SEL_CACHE, SEC_INSTR, FN_BTC_ALL, OP_BTC_FLUSH, TGT_NONE, 1'b0,
        1'b0);
    mop(SEL_CACHE, SEC_INSTR, FN_BTC_ONE, OP_BTC_FLUSH, TGT_NONE, 1'b1,
        1'b0);
    // unused codes stay unused; a plain register write issues nothing
    xfer(1'b1, SEL_DAC, 4'h0, 3'h0, 32'h0000_0000);
    chk("reg_no_maint", 32'h0, {31'h0, seen_req});
  endtask

  // ------------------------------------------------------------------
  // run control
  // ------------------------------------------------------------------
  task automatic finish_test;
    if (num_errors == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      finish_test();
    end
  end

  initial begin
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    t_reset();
    t_ctrl();
    t_ttb_dac();
    t_fault();
    t_user();
    t_maint();
    finish_test();
  end
endmodule // system_control_coprocessor_regs_bench
`default_nettype wire
